// [shared/odt_pkg.sv]
// Package: opcode classes, cycle types and state costs for the decoder
package odt_pkg;
  // Cycle type counts and state costs
  localparam int CNT_W = 4;
  localparam int STATES_W = 8;
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 8;
  localparam logic [3:0] S_FETCH = 4'h2;
  localparam logic [3:0] S_BRADDR = 4'h2;
  localparam logic [3:0] S_STACK = 4'h2;
  localparam logic [3:0] S_BYTE_MEM = 4'h2;
  localparam logic [3:0] S_BYTE_PER_FAST = 4'h2;
  localparam logic [3:0] S_BYTE_PER_SLOW = 4'h3;
  localparam logic [3:0] S_WORD_MEM = 4'h2;
  localparam logic [3:0] S_INTERNAL = 4'h1;
  localparam logic [7:0] RESET_OPCODE = 8'h00;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_ADD_IMM = 4'h1,
    OP_ADD_WITH_CARRY = 4'h2,
    OP_CMP_IMM = 4'h3,
    OP_SUBTRACT_WITH_BORROW = 4'h4,
    OP_OR_IMM = 4'h5,
    OP_XOR_IMM = 4'h6,
    OP_AND_IMM = 4'h7,
    OP_MOV_IMM = 4'h8,
    OP_BIT_SET = 4'h9,
    OP_SUBROUTINE_CALL = 4'hA,
    OP_MOV_STACK = 4'hB,
    OP_REG_ALU = 4'hC
  } odt_class_type;

  typedef struct packed {
    logic [CNT_W-1:0] fetch;
    logic [CNT_W-1:0] braddr;
    logic [CNT_W-1:0] stack;
    logic [CNT_W-1:0] byte_acc;
    logic [CNT_W-1:0] word_acc;
    logic [CNT_W-1:0] internal;
  } odt_cycles_type;

  typedef struct packed {
    logic byte_is_periph;
    logic periph_slow;
    logic word_is_periph;
  } odt_access_type;

  typedef struct packed {
    odt_class_type op_class;
    odt_cycles_type cycles;
    logic [STATES_W-1:0] states;
  } odt_result_type;
endpackage

// [rtl/odt_cost_sum.sv]
// Weighted sum of cycle counts times per-cycle state costs
`timescale 1ns/1ps
`default_nettype none
module odt_cost_sum (
  // Cycle counts and access location
  input wire odt_pkg::odt_cycles_type cycles,
  input wire odt_pkg::odt_access_type access,
  // Total states
  output logic [odt_pkg::STATES_W-1:0] states
);
  import odt_pkg::*;
  logic [3:0] s_byte;
  logic [STATES_W-1:0] acc;
  always_comb begin
    // Peripheral byte cost varies by module addressed
    if (access.byte_is_periph) begin
      s_byte = access.periph_slow ? S_BYTE_PER_SLOW : S_BYTE_PER_FAST;
    end else begin
      s_byte = S_BYTE_MEM;
    end
    // Widen before multiplying so large counts cannot wrap at 4 bits
    acc = STATES_W'(cycles.fetch) * STATES_W'(S_FETCH);
    acc = acc + STATES_W'(cycles.braddr) * STATES_W'(S_BRADDR);
    acc = acc + STATES_W'(cycles.stack) * STATES_W'(S_STACK);
    acc = acc + STATES_W'(cycles.byte_acc) * STATES_W'(s_byte);
    acc = acc + STATES_W'(cycles.word_acc) * STATES_W'(S_WORD_MEM);
    acc = acc + STATES_W'(cycles.internal) * STATES_W'(S_INTERNAL);
    states = acc;
  end
endmodule
`default_nettype wire

// [rtl/odt_decoder.sv]
// Opcode decoder with per-instruction execution state count
`timescale 1ns/1ps
`default_nettype none
module odt_decoder (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction in
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire odt_pkg::odt_access_type access,
  // Decoded result, registered
  output logic result_valid,
  output odt_pkg::odt_result_type result
);
  import odt_pkg::*;

  logic [7:0] opcode;
  odt_class_type cls;
  odt_cycles_type cyc;
  logic [STATES_W-1:0] states;
  logic valid_r, valid_nxt;
  odt_result_type res_r, res_nxt;

  assign opcode = instr_word[OPC_HI:OPC_LO];

  always_comb begin
    cls = OP_NONE;
    cyc = '0;
    cyc.fetch = CNT_W'(1);
    if (opcode[7]) begin
      // Immediate byte ops, one fetch each
      case (opcode[6:4])
        3'h0: cls = OP_ADD_IMM;
        3'h1: cls = OP_ADD_WITH_CARRY;
        3'h2: cls = OP_CMP_IMM;
        3'h3: cls = OP_SUBTRACT_WITH_BORROW;
        3'h4: cls = OP_OR_IMM;
        3'h5: cls = OP_XOR_IMM;
        3'h6: cls = OP_AND_IMM;
        default: cls = OP_MOV_IMM;
      endcase
    end else begin
      case (opcode)
        8'h08, 8'h09, 8'h0E, 8'h14, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1E,
        8'h1C, 8'h0C, 8'h0D: begin
          cls = OP_REG_ALU;
        end
        8'h7D, 8'h7F: begin
          // Bit set on register-indirect or absolute memory
          cls = OP_BIT_SET;
          cyc.fetch = CNT_W'(2);
          cyc.byte_acc = CNT_W'(2);
        end
        8'h5F: begin
          // Call through 8-bit memory-indirect address
          cls = OP_SUBROUTINE_CALL;
          cyc.fetch = CNT_W'(2);
          cyc.braddr = CNT_W'(1);
          cyc.stack = CNT_W'(1);
        end
        8'h6C, 8'h6D: begin
          // Push/pop share the predec/postinc MOV encodings
          cls = OP_MOV_STACK;
          cyc.word_acc = CNT_W'(1);
          cyc.internal = CNT_W'(2);
        end
        default: cls = OP_NONE;
      endcase
    end
  end

  odt_cost_sum u_cost (
    .cycles(cyc),
    .access(access),
    .states(states)
  );

  always_comb begin
    valid_nxt = instr_valid;
    res_nxt = res_r;
    if (instr_valid) begin
      res_nxt.op_class = cls;
      res_nxt.cycles = cyc;
      res_nxt.states = states;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      valid_r <= 1'b0;
      res_r <= '0;
    end else begin
      valid_r <= valid_nxt;
      res_r <= res_nxt;
    end
  end

  assign result_valid = valid_r;
  assign result = res_r;
endmodule
`default_nettype wire

// [verification/odt_mem_model.sv]
// Access location model for memory and peripherals
`timescale 1ns/1ps
`default_nettype none
module odt_mem_model (
  // Location: 0 or 1 memory, 2 fast, 3 slow peripheral
  input wire logic [1:0] region,
  // Location seen by the decoder
  output logic [2:0] access
);
  assign access = {region[1], &region, 1'b0};
endmodule
`default_nettype wire

// [verification/odt_props.sv]
// Checker for decoder class, cycle and state outputs
`timescale 1ns/1ps
`default_nettype none
module odt_props (
  // Watched ports
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire odt_pkg::odt_access_type access,
  input wire logic result_valid,
  input wire odt_pkg::odt_result_type result
);
  import odt_pkg::*;
  odt_cycles_type c;
  logic v;
  assign c = result.cycles;
  assign v = instr_valid;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_answer_next: assert property (v |=> result_valid)
    else $error("no answer");
  a_idle_hold: assert property (
    !v |=> !result_valid && $stable(result)) else $error("moved");
  a_imm_class: assert property (v && instr_word[15] |=>
    result.op_class == $past(instr_word[15:12]) - 4'h7) else $error("class");
  a_imm_fetch: assert property (
    v && instr_word[15] |=> c == 24'h100000) else $error("imm");
  a_bit_set: assert property (
    v && instr_word[15:8] == 8'h7D |=> c == 24'h200200) else $error("bit_set_op");
  a_call_cycles: assert property (
    v && instr_word[15:8] == 8'h5F |=> c == 24'h211000) else $error("call");
  a_stack_mov: assert property (v && instr_word[15:9] == 7'h36
    |=> result.op_class == OP_MOV_STACK) else $error("stack");
  a_state_sum: assert property (result_valid |->
    result.states == 8'(2 * (c.fetch + c.braddr + c.stack + c.word_acc)
    + c.internal + c.byte_acc * ($past(access[2] && access[1]) ? 3 : 2)))
    else $error("states");
  c_bit_set: cover property (v && instr_word[15:8] == 8'h7D);
  c_call: cover property (v && instr_word[15:8] == 8'h5F);
  c_slow: cover property (v && access[1]);
endmodule
bind odt_decoder odt_props i_props (.clk(clk), .rst(rst),
  .instr_valid(instr_valid), .instr_word(instr_word), .access(access),
  .result_valid(result_valid), .result(result));
`default_nettype wire

// [verification/opcode_decode_and_state_timing_bench.sv]
// Bench for the opcode decoder and state count
`timescale 1ns/1ps
`default_nettype none
module opcode_decode_and_state_timing_bench;
  import odt_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic instr_valid = 0;
  logic [15:0] instr_word = 16'h0000;
  logic [1:0] region = 2'h0;
  logic [2:0] acc;
  logic result_valid;
  odt_result_type result;
  int failures = 0;
  int checks_done = 0;
  initial forever #2.5 clk = ~clk;
  odt_mem_model i_mem (.region(region), .access(acc));
  odt_decoder i_dut (.clk(clk), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .access(acc),
    .result_valid(result_valid), .result(result));
  task chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Leaves valid high so that calls run back to back
  task op(input logic [15:0] w, input logic [1:0] r);
    instr_valid = 1;
    instr_word = w;
    region = r;
    @(posedge clk);
    #1;
    chk(result_valid, 24'h1);
  endtask
  task t_imm;
    for (int n = 8; n < 16; n++) begin
      op({4'(n), 12'h07D}, 2'h0);
      chk(result.op_class, 24'(n - 7));
      chk(result.cycles, 24'h100000);
      chk(result.states, 24'h2);
    end
  endtask
  task t_bit_set_op;
    for (int r = 0; r < 4; r++) begin
      op(16'h7D00, 2'(r));
      chk(result.cycles, 24'h200200);
      chk(result.states, (r == 3) ? 24'hA : 24'h8);
    end
  endtask
  task t_call;
    op(16'h5F30, 2'h0);
    chk(result.cycles, 24'h211000);
    chk(result.states, 24'h8);
  endtask
  task t_reg;
    op(16'h0812, 2'h3);
    chk(result.op_class, OP_REG_ALU);
    chk(result.cycles, 24'h100000);
    chk(result.states, 24'h2);
  endtask
  task t_stack;
    op(16'h6D70, 2'h0);
    chk(result.op_class, OP_MOV_STACK);
    chk(result.states, 24'h6);
    op(16'h6CF0, 2'h0);
    chk(result.op_class, OP_MOV_STACK);
    instr_valid = 0;
    @(posedge clk);
    #1;
    chk(result_valid, 24'h0);
    chk(result.op_class, OP_MOV_STACK);
  endtask
  task end_of_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst = 0;
    t_imm;
    t_call;
    t_bit_set_op;
    t_reg;
    t_stack;
    end_of_test;
  end
endmodule
`default_nettype wire
